/* File: rtl/iic_ctrl.sv */
// two-wire bus master/slave controller with an AXI4-Lite register slave
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "iic_params.svh"

module iic_ctrl
  import iic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // two-wire bus pins, open drain
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe
);

  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  localparam int BUS_FREE_CYC = (`IIC_BUS_FREE_NS * `IIC_CLK_MHZ + 999) / 1000;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        o);
    return a == ADDR_W'(o);
  endfunction : hit

  function automatic logic reached(input iic_cnt_t    c,
                                   input logic [15:0] lim);
    return (c + 17'd1) >= {1'b0, lim};
  endfunction : reached

  function automatic logic [15:0] wmask(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : wmask

  iic_state_e  st_q;
  iic_cnt_t    cnt_q;
  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  logic [7:0]  sar_q;
  logic [7:0]  data_q;
  logic [7:0]  rx_sh_q;
  logic [15:0] clock_high_duration_q, clock_low_duration_q, free_q;
  logic [3:0]  bit_q;
  logic        fresh_q, addr_ph_q, ack_rx_q, busy_q;
  logic        start_q, stop_q, ack_en_q, mscl_q, hold_q;
  logic        evt_q, lost_q, slv_act_q, tmode_q, sda_oe_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        start_det, stop_det, scl_rise, scl_fall;
  logic        byte_evt, addr_fall, match, mst_drive, arb_hit, up_done;
  logic        drv_low, wr_go, rd_go, sr_wr, wmap, rmap;
  logic [31:0] sr_w;

  // synchronisers; third stage only for edge finding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign byte_evt  = scl_fall & ~fresh_q & (bit_q == `IIC_ACK_SLOT);
  assign addr_fall = scl_fall & ~fresh_q & addr_ph_q
                     & (bit_q == `IIC_LAST_BIT);
  assign mst_drive = (st_q != ST_IDLE) & ~lost_q;
  assign match     = (rx_sh_q[7:1] == sar_q[7:1])
                     | (sar_q[0] & (rx_sh_q[7:1] == `IIC_GCALL_ADDR));

  // bus bit tracker; the fall that a start itself makes is not a bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_q    <= 4'h0;
      fresh_q  <= 1'b1;
      rx_sh_q  <= 8'h00;
      ack_rx_q <= 1'b1;
    end else if (start_det) begin
      bit_q   <= 4'h0;
      fresh_q <= 1'b1;
    end else begin
      if (scl_rise && !fresh_q) begin
        if (bit_q != `IIC_ACK_SLOT) begin
          rx_sh_q <= {rx_sh_q[6:0], sda_s_q};
        end else begin
          ack_rx_q <= sda_s_q;
        end
      end
      if (scl_fall) begin
        if (fresh_q) begin
          fresh_q <= 1'b0;
        end else if (bit_q == `IIC_ACK_SLOT) begin
          bit_q <= 4'h0;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ph_q <= 1'b0;
    end else if (start_det) begin
      addr_ph_q <= 1'b1;
    end else if (byte_evt) begin
      addr_ph_q <= 1'b0;
    end
  end

  // busy until a free time after stop; repeated start keeps it set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      free_q <= 16'h0;
    end else if (start_det) begin
      busy_q <= 1'b1;
      free_q <= 16'h0;
    end else if (stop_det) begin
      free_q <= 16'(BUS_FREE_CYC);
    end else if (free_q != 16'h0) begin
      free_q <= free_q - 16'h1;
      if (free_q == 16'h1) begin
        busy_q <= 1'b0;
      end
    end
  end

  // register bus
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_go = s_axi_arvalid & ~rvalid_q;
  assign sr_wr = wr_go & hit(s_axi_awaddr, `IIC_OFS_SR);
  assign wmap  = hit(s_axi_awaddr, `IIC_OFS_SAR)
                 | hit(s_axi_awaddr, `IIC_OFS_DATA) | sr_wr
                 | hit(s_axi_awaddr, `IIC_OFS_CLOCK_HIGH_DURATION)
                 | hit(s_axi_awaddr, `IIC_OFS_CR)
                 | hit(s_axi_awaddr, `IIC_OFS_CLOCK_LOW_DURATION);
  assign rmap  = hit(s_axi_araddr, `IIC_OFS_SAR)
                 | hit(s_axi_araddr, `IIC_OFS_DATA)
                 | hit(s_axi_araddr, `IIC_OFS_SR)
                 | hit(s_axi_araddr, `IIC_OFS_CLOCK_HIGH_DURATION)
                 | hit(s_axi_araddr, `IIC_OFS_CR)
                 | hit(s_axi_araddr, `IIC_OFS_CLOCK_LOW_DURATION);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sar_q    <= `IIC_SAR_RST;
      clock_high_duration_q   <= `IIC_CLOCK_HIGH_DURATION_RST;
      clock_low_duration_q   <= `IIC_CLOCK_LOW_DURATION_RST;
      ack_en_q <= 1'b0;
    end else if (wr_go) begin
      if (hit(s_axi_awaddr, `IIC_OFS_SAR) && s_axi_wstrb[0]) begin
        sar_q <= s_axi_wdata[7:0];
      end
      if (hit(s_axi_awaddr, `IIC_OFS_CLOCK_HIGH_DURATION)) begin
        clock_high_duration_q <= wmask(clock_high_duration_q, s_axi_wdata, s_axi_wstrb);
      end
      if (hit(s_axi_awaddr, `IIC_OFS_CLOCK_LOW_DURATION)) begin
        clock_low_duration_q <= wmask(clock_low_duration_q, s_axi_wdata, s_axi_wstrb);
      end
      if (hit(s_axi_awaddr, `IIC_OFS_CR) && s_axi_wstrb[0]) begin
        ack_en_q <= s_axi_wdata[`IIC_CR_ACKEN];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `IIC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wmap ? `IIC_RESP_OKAY : `IIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    sr_w                = 32'h0;
    sr_w[`IIC_SR_EVT]   = evt_q;
    sr_w[`IIC_SR_SLV]   = slv_act_q;
    sr_w[`IIC_SR_LOST]  = lost_q;
    sr_w[`IIC_SR_BUSY]  = busy_q;
    sr_w[`IIC_SR_TMODE] = tmode_q;
    sr_w[`IIC_SR_RXACK] = ~ack_rx_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `IIC_RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rmap ? `IIC_RESP_OKAY : `IIC_RESP_SLVERR;
      rdata_q  <= 32'h0;
      if (hit(s_axi_araddr, `IIC_OFS_SAR)) rdata_q <= {24'h0, sar_q};
      if (hit(s_axi_araddr, `IIC_OFS_DATA)) rdata_q <= {24'h0, data_q};
      if (hit(s_axi_araddr, `IIC_OFS_SR)) rdata_q <= sr_w;
      if (hit(s_axi_araddr, `IIC_OFS_CLOCK_HIGH_DURATION)) rdata_q <= {16'h0, clock_high_duration_q};
      if (hit(s_axi_araddr, `IIC_OFS_CLOCK_LOW_DURATION)) rdata_q <= {16'h0, clock_low_duration_q};
      if (hit(s_axi_araddr, `IIC_OFS_CR)) begin
        rdata_q[`IIC_CR_START] <= start_q;
        rdata_q[`IIC_CR_STOP]  <= stop_q;
        rdata_q[`IIC_CR_ACKEN] <= ack_en_q;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // received bytes land in the data register; software refills it when tx
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= 8'h00;
    end else if (byte_evt && !tmode_q && !addr_ph_q
                 && (mst_drive || slv_act_q)) begin
      data_q <= rx_sh_q;
    end else if (wr_go && hit(s_axi_awaddr, `IIC_OFS_DATA)
                 && s_axi_wstrb[0]) begin
      data_q <= s_axi_wdata[7:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_q  <= 1'b0;
      lost_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      if (sr_wr) begin
        evt_q  <= 1'b0;
        lost_q <= 1'b0;
        hold_q <= 1'b0;
      end
      if (byte_evt && (st_q != ST_IDLE || slv_act_q)) begin
        evt_q <= 1'b1;
      end
      if (byte_evt && slv_act_q) begin
        hold_q <= 1'b1;
      end
      if (arb_hit) begin
        lost_q <= 1'b1;
      end
    end
  end

  // slave side: a master that lost drops mst_drive and competes here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slv_act_q <= 1'b0;
    end else if (start_det || stop_det) begin
      slv_act_q <= 1'b0;
    end else if (addr_fall && !mst_drive && match) begin
      slv_act_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmode_q <= 1'b0;
    end else if (st_q == ST_START) begin
      tmode_q <= 1'b1;
    end else if (addr_fall) begin
      if (mst_drive) begin
        tmode_q <= ~data_q[0];
      end else if (match) begin
        tmode_q <= rx_sh_q[0];
      end
    end
  end

  // arbitration: released but read low while clock is high
  assign arb_hit = (st_q == ST_HIGH) && (cnt_q == 17'h0) && mst_drive
                   && !sda_oe_q && !sda_s_q && !fresh_q
                   && (((bit_q != `IIC_ACK_SLOT) && tmode_q)
                       || ((bit_q == `IIC_ACK_SLOT) && !tmode_q
                           && !addr_ph_q));

  // master clock engine; line high time is clock_high_duration plus sync and output lag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 17'h0;
      mscl_q  <= 1'b0;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      if (wr_go && hit(s_axi_awaddr, `IIC_OFS_CR) && s_axi_wstrb[0]) begin
        start_q <= s_axi_wdata[`IIC_CR_START];
        stop_q  <= s_axi_wdata[`IIC_CR_STOP];
      end
      case (st_q)
        ST_IDLE: begin
          mscl_q <= 1'b0;
          cnt_q  <= 17'h0;
          if (start_q && !busy_q && !lost_q) begin
            st_q <= ST_START;
          end
        end
        ST_START: begin
          cnt_q <= cnt_q + 17'h1;
          if (reached(cnt_q, clock_high_duration_q)) begin
            mscl_q  <= 1'b1;
            cnt_q   <= 17'h0;
            start_q <= 1'b0;
            st_q    <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (stop_q && mst_drive) begin
            cnt_q <= 17'h0;
            st_q  <= ST_PRE;
          end else if (!scl_s_q) begin
            cnt_q <= cnt_q + 17'h1;
            if (reached(cnt_q, clock_low_duration_q)) begin
              mscl_q <= 1'b0;
              cnt_q  <= 17'h0;
              st_q   <= ST_RISE;
            end
          end
        end
        ST_RISE: begin
          if (scl_s_q) begin
            st_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt_q <= cnt_q + 17'h1;
          if (reached(cnt_q, clock_high_duration_q)) begin
            cnt_q <= 17'h0;
            if (bit_q != `IIC_ACK_SLOT) begin
              mscl_q <= 1'b1;
              st_q   <= ST_LOW;
            end else if (lost_q) begin
              st_q <= ST_IDLE;
            end else begin
              mscl_q <= 1'b1;
              st_q   <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (sr_wr) begin
            cnt_q <= 17'h0;
            st_q  <= (stop_q || start_q) ? ST_PRE : ST_LOW;
          end
        end
        ST_PRE: begin
          if (!scl_s_q) begin
            cnt_q <= cnt_q + 17'h1;
            if (reached(cnt_q, clock_low_duration_q)) begin
              mscl_q <= 1'b0;
              cnt_q  <= 17'h0;
              st_q   <= ST_UP;
            end
          end
        end
        ST_UP: begin
          if (scl_s_q) begin
            cnt_q <= cnt_q + 17'h1;
            if (reached(cnt_q, clock_high_duration_q)) begin
              cnt_q <= 17'h0;
              if (stop_q) begin
                stop_q <= 1'b0;
                st_q   <= ST_IDLE;
              end else begin
                st_q <= ST_START;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign up_done = (st_q == ST_UP) && scl_s_q && stop_q
                   && reached(cnt_q, clock_high_duration_q);

  // data wire wish for the current bit; applied only while clock is low
  always_comb begin
    drv_low = 1'b0;
    if (bit_q != `IIC_ACK_SLOT) begin
      drv_low = (mst_drive | slv_act_q) & tmode_q
                & ~data_q[~bit_q[2:0]];
    end else if (addr_ph_q) begin
      drv_low = slv_act_q;
    end else begin
      drv_low = (mst_drive | slv_act_q) & ~tmode_q
                & ack_en_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_oe_q <= 1'b0;
    end else if (st_q == ST_START) begin
      sda_oe_q <= 1'b1;
    end else if (st_q == ST_PRE) begin
      if (!scl_s_q) begin
        sda_oe_q <= stop_q;
      end
    end else if (up_done) begin
      sda_oe_q <= 1'b0;
    end else if (arb_hit) begin
      sda_oe_q <= 1'b0;
    end else if (st_q != ST_UP && !scl_s_q) begin
      sda_oe_q <= drv_low;
    end
  end

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = mscl_q | hold_q;
  assign sda_oe = sda_oe_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [16:0] hi_len_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_len_q <= 17'h0;
    end else begin
      hi_len_q <= (st_q == ST_HIGH) ? hi_len_q + 17'h1 : 17'h0;
    end
  end

  property p_sda_low_clk;
    $changed(sda_oe_q) && !($past(st_q) inside {ST_START, ST_UP})
      && !$past(arb_hit) |-> !$past(scl_s_q);
  endproperty
  a_sda_low_clk: assert property (p_sda_low_clk)
    else $error("data wire changed while clock high");

  property p_free_start;
    st_q == ST_IDLE ##1 st_q == ST_START |-> !$past(busy_q);
  endproperty
  a_free_start: assert property (p_free_start)
    else $error("master start while bus busy");

  property p_busy_set;
    start_det |=> busy_q [*2];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not set after start");

  property p_arb_release;
    arb_hit |=> !sda_oe_q && lost_q ##1 !sda_oe_q;
  endproperty
  a_arb_release: assert property (p_arb_release)
    else $error("data driven after arbitration loss");

  property p_evt_hold;
    byte_evt && slv_act_q |=> evt_q && scl_oe;
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("byte end did not flag or hold clock");

  property p_sr_clear;
    sr_wr && !byte_evt && !arb_hit |=> !evt_q && !lost_q && !hold_q;
  endproperty
  a_sr_clear: assert property (p_sr_clear)
    else $error("status write did not clear");

  property p_wait_stretch;
    st_q == ST_RISE && !scl_s_q |=> st_q == ST_RISE && !mscl_q;
  endproperty
  a_wait_stretch: assert property (p_wait_stretch)
    else $error("master did not wait for clock release");

  property p_high_len;
    $fell(st_q == ST_HIGH) |->
      hi_len_q == ((clock_high_duration_q == 16'h0) ? 17'd1 : {1'b0, clock_high_duration_q});
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("clock high time wrong");

  property p_slave_match;
    $rose(slv_act_q) |-> $past(match) && $past(addr_fall);
  endproperty
  a_slave_match: assert property (p_slave_match)
    else $error("slave addressed without match");

  property p_lost_end;
    lost_q && st_q == ST_HIGH && bit_q == `IIC_ACK_SLOT
      && reached(cnt_q, clock_high_duration_q) |=> st_q == ST_IDLE && !mscl_q;
  endproperty
  a_lost_end: assert property (p_lost_end)
    else $error("clocking went on past the lost byte");

  c_master_start: cover property (st_q == ST_IDLE ##1 st_q == ST_START);
  c_byte_event:   cover property ($rose(evt_q));
  c_arb_lost:     cover property ($rose(lost_q));
  c_slave_addr:   cover property ($rose(slv_act_q));

endmodule : iic_ctrl

/* File: rtl/iic_params.svh */
// constants of the two-wire bus controller: offsets, fields, resets, timing
// Notes on behaviour
// - data wire changes only while the clock wire is low.
// - data falling with clock high is start; rising with clock high is stop.
// - only the acting master generates start and stop conditions.
// - bus busy from start until a free time after stop; repeated start alike.
// - every byte is exactly eight bits; any number of bytes per transfer.
// - each byte is followed by one acknowledge slot.
// - bits go out most significant bit first.
// - a slave may hold the clock low; the master waits for release.
// - a stop may end a transfer mid-byte, with no acknowledge slot.
// - master clocks the acknowledge slot; the transmitter releases data there.
// - receiver pulls data low through the high phase of the acknowledge pulse.
// - unaddressed slave leaves data high; master then stops or restarts.
// - a full slave receiver does not acknowledge; master stops or restarts.
// - master receiver does not acknowledge its last byte.
// - each master times its low period; clock rises only when all release.
// - each master times its high period; the first finished pulls clock low.
// - a master transfer begins only while the bus is free.
// - driving high but reading low in clock high: release data at once.
// - arbitration spans address, then data or acknowledge bits.
// - after a loss, clocking continues only to the end of that byte.
// - a loss during the address byte switches to slave operation at once.
// - each byte end sets the event flag and holds clock low until status write.
// - a status write clears the flags and releases the held clock.
// - slave compares a 7-bit own address; general call accepted when enabled.
// - start bit launches master operation; stop bit ends the transfer.
// - master clock high time is high-duration clocks plus three.
// - arbitration loss shows in a sticky mastership-lost flag.
`ifndef IIC_PARAMS_SVH
`define IIC_PARAMS_SVH

`define IIC_OFS_SAR      8'h00
`define IIC_OFS_DATA     8'h04
`define IIC_OFS_SR       8'h08
`define IIC_OFS_CLOCK_HIGH_DURATION     8'h10
`define IIC_OFS_CR       8'h14
`define IIC_OFS_CLOCK_LOW_DURATION     8'h18

`define IIC_SR_EVT       10
`define IIC_SR_SLV       4
`define IIC_SR_LOST      3
`define IIC_SR_BUSY      2
`define IIC_SR_TMODE     1
`define IIC_SR_RXACK     0

`define IIC_CR_START     0
`define IIC_CR_STOP      1
`define IIC_CR_ACKEN     3

`define IIC_SAR_RST      8'h00
`define IIC_CLOCK_HIGH_DURATION_RST     16'hffff
`define IIC_CLOCK_LOW_DURATION_RST     16'hffff
`define IIC_HIGH_EXTRA   3
`define IIC_ACK_SLOT     4'h8
`define IIC_LAST_BIT     4'h7
`define IIC_GCALL_ADDR   7'h00
`define IIC_BUS_FREE_NS  500
`define IIC_CLK_MHZ      100

`define IIC_RESP_OKAY    2'h0
`define IIC_RESP_SLVERR  2'h2

`endif

/* File: rtl/iic_pkg.sv */
// types of the two-wire bus controller
package iic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_LOW   = 3'b010,
    ST_RISE  = 3'b011,
    ST_HIGH  = 3'b100,
    ST_WAIT  = 3'b101,
    ST_PRE   = 3'b110,
    ST_UP    = 3'b111
  } iic_state_e;

  typedef logic [16:0] iic_cnt_t;

endpackage : iic_pkg

/* File: sim/iic_ctrl_tb_top.sv */
// self-checking bench of the two-wire controller
`timescale 1ns/1ps
module iic_ctrl_tb_top;
  logic        clk, nrst, awv, wv, bry, arv, rry;
  logic [7:0]  awa, ara;
  logic [31:0] wd, v;
  logic [1:0]  r;
  wire  [31:0] rdat;
  wire  [1:0]  bresp, rresp;
  wire         awr, wrd, bv, arr, rv, scl_oe, sda_oe, m_oe, sclo, sdao;
  wire  [7:0]  rx;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe | m_oe);
  int          n_fail, compares;
  // address, expected data, expected response
  logic [31:0] rows [6][3] = '{'{32'h00, 32'h0, 32'h0},
    '{32'h10, 32'hffff, 32'h0}, '{32'h18, 32'hffff, 32'h0},
    '{32'h14, 32'h0, 32'h0}, '{32'h08, 32'h0, 32'h0},
    '{32'h0c, 32'h0, 32'h2}};

  iic_ctrl dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .scl_i(scl), .scl_o(sclo), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sdao), .sda_oe(sda_oe));
  iic_slv_model #(.ADR(7'h52)) slv (.scl(scl), .sda(sda),
    .sda_oe(m_oe), .rx(rx));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // ready is looked at mid-cycle so the taking edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
    do @(negedge clk); while (awr !== 1'b1);
    @(posedge clk);
    {awv, wv} <= 2'b00;
    do @(negedge clk); while (bv !== 1'b1);
    r = bresp;
    @(posedge clk);
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    {v, r} = {rdat, rresp};
    @(posedge clk);
    rry <= 1'b0;
  endtask : rd
  task automatic poll(input int b, input logic x);
    do rd(8'h08); while (v[b] !== x);
  endtask : poll
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    n_fail++;
    final_report();
  end
  initial begin
    {nrst, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    repeat (20) @(negedge clk);
    chk(32'({scl_oe, sda_oe, sclo, sdao}), 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      rd(rows[i][0][7:0]);
      chk(v, rows[i][1]);
      chk(32'(r), rows[i][2]);
    end
    wr(8'h0c, 32'h1);
    chk(32'(r), 32'h2);
    $display("test registers done");
    wr(8'h10, 32'h5);
    wr(8'h18, 32'h6);
    rd(8'h10);
    chk(v, 32'h5);
    wr(8'h00, 32'ha5);
    rd(8'h00);
    chk(v, 32'ha5);
    wr(8'h14, 32'h8);
    rd(8'h14);
    chk(v, 32'h8);
    // one acked address, one that nobody answers
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, k ? 32'h62 : 32'ha4);
      wr(8'h14, 32'h1);
      poll(10, 1'b1);
      chk(32'(rx), k ? 32'h62 : 32'ha4);
      chk(32'(v[1:0]), k ? 32'h2 : 32'h3);
      chk(32'(scl_oe), 32'h1);
      wr(8'h14, 32'h2);
      wr(8'h08, 32'h0);
      poll(2, 1'b0);
      chk(32'({scl, sda, v[10]}), 32'h6);
      $display("test transfer %0d done", k);
    end
    // stop while the address byte is still on the wire
    wr(8'h04, 32'ha4);
    wr(8'h14, 32'h1);
    poll(2, 1'b1);
    wr(8'h14, 32'h2);
    poll(2, 1'b0);
    chk(32'({v[10], m_oe}), 32'h0);
    $display("test stop mid-byte done");
    // reset mid-byte: pins let go, the high-duration register returns to its reset value
    wr(8'h14, 32'h1);
    poll(2, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'({scl_oe, sda_oe, bv, rv}), 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(8'h10);
    chk(v, 32'hffff);
    $display("test reset mid-run done");
    final_report();
  end
endmodule : iic_ctrl_tb_top

/* File: sim/iic_slv_model.sv */
// far-side slave model: takes one address byte and acks on a match
`timescale 1ns/1ps
module iic_slv_model #(
  parameter logic [6:0] ADR = 7'h52
) (
  // bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // pull-down and capture
  output logic            sda_oe,
  output logic [7:0]      rx
);
  int n;
  initial begin
    sda_oe = 1'b0;
    rx = 8'h00;
    n = 10;
  end
  always @(negedge sda) if (scl) n = 0;
  always @(posedge scl) if (n < 8) begin
    rx = {rx[6:0], sda};
    n++;
  end
  // ack only once the byte is whole; mismatch leaves data high
  always @(negedge scl) begin
    if (n == 8 && rx[7:1] == ADR) begin
      sda_oe <= 1'b1;
      n = 9;
    end else if (n == 9) begin
      sda_oe <= 1'b0;
      n = 10;
    end
  end
endmodule : iic_slv_model
